// File: core/int_flag_consts.vh
`ifndef INT_FLAG_CONSTS_VH
`define INT_FLAG_CONSTS_VH
`define ADDR_W 4
`define DATA_W 16
`define ADDR_FLAGS_A 4'h0
`define ADDR_USB_FLAGS 4'h1
`define BIT_CHARGE_TIME 13
`define BIT_LOW_VOLTAGE 8
`define BIT_CRC 3
`define BIT_UART2_ERR 2
`define BIT_UART1_ERR 1
`define BIT_USB 6
`define FLAGS_A_MASK 16'h210e
`define USB_FLAGS_MASK 16'h0040
`define FLAGS_RESET 16'h0000
`define FLAG_RESET_BIT 1'h0
`define FLAG_SET_BIT 1'h1
`endif

// File: core/interrupt_flag_status_bank.v
// Summary of operation
// - usb event flag is bit 6 of usb_event_flags, set by usb request
// - each flag latches 1 on its request and holds it until software writes 0 or reset
// - usb_event_flags bits 15..7 hold nothing and read zero
// - usb_event_flags bits 5..0 hold nothing and read zero
`timescale 1ns/100ps
`include "int_flag_consts.vh"
module interrupt_flag_status_bank (
    core_clk,
    reset_n,
    reg_addr,
    reg_wdata,
    reg_write,
    reg_read,
    reg_rdata,
    charge_time_req,
    low_voltage_req,
    crc_req,
    serial_port_two_error_req,
    serial_port_one_error_req,
    usb_req,
    peripheral_event_flags_a,
    usb_event_flags
);
    input wire core_clk;
    input wire reset_n;
    input wire [`ADDR_W-1:0] reg_addr;
    input wire [`DATA_W-1:0] reg_wdata;
    input wire reg_write;
    input wire reg_read;
    output reg [`DATA_W-1:0] reg_rdata;
    input wire charge_time_req;
    input wire low_voltage_req;
    input wire crc_req;
    input wire serial_port_two_error_req;
    input wire serial_port_one_error_req;
    input wire usb_req;
    output wire [`DATA_W-1:0] peripheral_event_flags_a;
    output wire [`DATA_W-1:0] usb_event_flags;

    reg wr_flags_a;
    reg wr_usb_flags;
    reg rd_flags_a;
    reg rd_usb_flags;
    reg [`DATA_W-1:0] flags_a_view;
    reg [`DATA_W-1:0] usb_flags_view;
    reg [`DATA_W-1:0] rdata_d;
    wire charge_time_event_flag;
    wire low_voltage_event_flag;
    wire crc_event_flag;
    wire serial_port_two_error_flag;
    wire serial_port_one_error_flag;
    wire usb_event_flag;

    // one write strobe per register; unmapped addresses strobe nothing
    always @* begin
        wr_flags_a = 1'h0;
        wr_usb_flags = 1'h0;
        if (reg_write && reg_addr == `ADDR_FLAGS_A) begin
            wr_flags_a = 1'h1;
        end else if (reg_write && reg_addr == `ADDR_USB_FLAGS) begin
            wr_usb_flags = 1'h1;
        end
    end

    // read decode kept apart so a write never disturbs read data
    always @* begin
        rd_flags_a = 1'h0;
        rd_usb_flags = 1'h0;
        if (reg_read && reg_addr == `ADDR_FLAGS_A) begin
            rd_flags_a = 1'h1;
        end else if (reg_read && reg_addr == `ADDR_USB_FLAGS) begin
            rd_usb_flags = 1'h1;
        end
    end

    // requests come from peripherals on core_clk, so no synchroniser
    // first register: five live positions
    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) charge_time_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(charge_time_req),
        .wr_en(wr_flags_a),
        .wr_bit(reg_wdata[`BIT_CHARGE_TIME]),
        .flag_q(charge_time_event_flag)
    );

    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) low_voltage_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(low_voltage_req),
        .wr_en(wr_flags_a),
        .wr_bit(reg_wdata[`BIT_LOW_VOLTAGE]),
        .flag_q(low_voltage_event_flag)
    );

    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) crc_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(crc_req),
        .wr_en(wr_flags_a),
        .wr_bit(reg_wdata[`BIT_CRC]),
        .flag_q(crc_event_flag)
    );

    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) serial_two_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(serial_port_two_error_req),
        .wr_en(wr_flags_a),
        .wr_bit(reg_wdata[`BIT_UART2_ERR]),
        .flag_q(serial_port_two_error_flag)
    );

    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) serial_one_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(serial_port_one_error_req),
        .wr_en(wr_flags_a),
        .wr_bit(reg_wdata[`BIT_UART1_ERR]),
        .flag_q(serial_port_one_error_flag)
    );

    // second register: a single live position
    flag_cell #(
        .RESET_VALUE(`FLAG_RESET_BIT)
    ) usb_cell_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .set_req(usb_req),
        .wr_en(wr_usb_flags),
        .wr_bit(reg_wdata[`BIT_USB]),
        .flag_q(usb_event_flag)
    );

    // unimplemented positions are constant zero, so writes to them vanish
    always @* begin
        flags_a_view = `FLAGS_RESET;
        flags_a_view[`BIT_CHARGE_TIME] = charge_time_event_flag;
        flags_a_view[`BIT_LOW_VOLTAGE] = low_voltage_event_flag;
        flags_a_view[`BIT_CRC] = crc_event_flag;
        flags_a_view[`BIT_UART2_ERR] = serial_port_two_error_flag;
        flags_a_view[`BIT_UART1_ERR] = serial_port_one_error_flag;
        usb_flags_view = `FLAGS_RESET;
        usb_flags_view[`BIT_USB] = usb_event_flag;
    end

    // unmapped reads and idle cycles give zero
    always @* begin
        rdata_d = `FLAGS_RESET;
        if (rd_flags_a) begin
            rdata_d = flags_a_view;
        end else if (rd_usb_flags) begin
            rdata_d = usb_flags_view;
        end
    end

    // read data stands one cycle for each cycle that reg_read is held, then falls back to zero
    always @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= `FLAGS_RESET;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // flag views also leave the block for the vectoring logic
    assign peripheral_event_flags_a = flags_a_view;
    assign usb_event_flags = usb_flags_view;
endmodule // interrupt_flag_status_bank

// one latched request flag, shared by every implemented position
module flag_cell #(
    parameter RESET_VALUE = `FLAG_RESET_BIT
) (
    core_clk,
    reset_n,
    set_req,
    wr_en,
    wr_bit,
    flag_q
);
    input wire core_clk;
    input wire reset_n;
    input wire set_req;
    input wire wr_en;
    input wire wr_bit;
    output reg flag_q;

    // all flags clear at reset; kept a parameter for reuse
    reg flag_d;

    // software may also write ones, which sets a flag as on the real bank
    always @* begin
        flag_d = flag_q;
        if (wr_en) begin
            flag_d = wr_bit;
        end
        // set last so a same-cycle clear can never swallow an event
        if (set_req) begin
            flag_d = `FLAG_SET_BIT;
        end
    end

    always @(posedge core_clk) begin
        if (!reset_n) begin
            flag_q <= RESET_VALUE;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // flag_cell

// File: testbench/flag_bank_monitor.sv
`timescale 1ns/100ps
module flag_bank_monitor (
    input wire core_clk,
    input wire reset_n,
    input wire reg_write,
    input wire reg_read,
    input wire crc_req,
    input wire usb_req,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire [15:0] peripheral_event_flags_a,
    input wire [15:0] usb_event_flags
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    usb_flag_set_a: assert property (usb_req |=> usb_event_flags[6])
        else $error("usb flag not set");
    usb_flag_fall_a: assert property ($fell(usb_event_flags[6]) |->
        $past(!reset_n || (reg_write && reg_addr == 4'h1 && !reg_wdata[6])))
        else $error("usb flag lost");
    usb_high_zero_a: assert property (reg_read && reg_addr == 4'h1 |=>
        reg_rdata[15:7] == 9'h000) else $error("usb high bits set");
    usb_low_zero_a: assert property (reg_read && reg_addr == 4'h1 |=>
        reg_rdata[5:0] == 6'h00) else $error("usb low bits set");
    crc_flag_set_a: assert property (crc_req |=> peripheral_event_flags_a[3])
        else $error("crc flag not set");
    set_beats_clear_a: assert property (crc_req && reg_write && reg_addr == 4'h0 |=>
        peripheral_event_flags_a[3]) else $error("clear beat request");
    cover property (crc_req && reg_write);
    cover property (reg_read && reg_addr == 4'h1);
    cover property (usb_req);
endmodule // flag_bank_monitor
bind interrupt_flag_status_bank flag_bank_monitor flag_bank_monitor_inst (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .crc_req(crc_req),
    .usb_req(usb_req),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .peripheral_event_flags_a(peripheral_event_flags_a),
    .usb_event_flags(usb_event_flags)
);

// File: testbench/interrupt_flag_status_bank_bench.sv
`timescale 1ns/100ps
`include "int_flag_consts.vh"
module interrupt_flag_status_bank_bench;
    reg core_clk = 1'h0;
    reg reset_n = 1'h0;
    reg reg_write = 1'h0;
    reg reg_read = 1'h0;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg [5:0] rq = 6'h00;
    wire [15:0] reg_rdata;
    wire [15:0] flags_a;
    wire [15:0] usb_flags;
    integer err_total = 0;
    integer compares = 0;
    interrupt_flag_status_bank interrupt_flag_status_bank_inst (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .charge_time_req(rq[5]),
        .low_voltage_req(rq[4]),
        .crc_req(rq[3]),
        .serial_port_two_error_req(rq[2]),
        .serial_port_one_error_req(rq[1]),
        .usb_req(rq[0]),
        .peripheral_event_flags_a(flags_a),
        .usb_event_flags(usb_flags)
    );
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task chk(input string nm, input [15:0] seen, input [15:0] exp); begin
        compares = compares + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    end endtask
    // one strobe plus optional requests; read data sampled in the cycle after the strobe
    task acc(input w, input [3:0] a, input [15:0] d, input [5:0] r); begin
        @(posedge core_clk);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        rq <= r;
        @(posedge core_clk);
        reg_write <= 1'h0;
        reg_read <= 1'h0;
        rq <= 6'h00;
        #1;
    end endtask
    task results; begin
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    end endtask
    initial begin
        #20000;
        err_total = err_total + 1;
        results;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'h1;
        #1;
        chk("flags a reset", flags_a, `FLAGS_RESET);
        chk("usb reset", usb_flags, `FLAGS_RESET);
        acc(1'h0, `ADDR_USB_FLAGS, 16'h0000, 6'h00);
        chk("usb idle", reg_rdata, `FLAGS_RESET);
        // unmapped write ignored while all sources fire
        acc(1'h1, 4'hf, 16'hffff, 6'h3f);
        chk("flags a port", flags_a, `FLAGS_A_MASK);
        chk("usb port", usb_flags, `USB_FLAGS_MASK);
        acc(1'h0, `ADDR_FLAGS_A, 16'h0000, 6'h00);
        chk("flags a", reg_rdata, `FLAGS_A_MASK);
        acc(1'h0, `ADDR_USB_FLAGS, 16'h0000, 6'h00);
        chk("usb set", reg_rdata, `USB_FLAGS_MASK);
        acc(1'h1, `ADDR_USB_FLAGS, 16'hffbf, 6'h00);
        acc(1'h0, `ADDR_USB_FLAGS, 16'h0000, 6'h00);
        chk("usb clear", reg_rdata, 16'h0000);
        chk("usb port clear", usb_flags, 16'h0000);
        acc(1'h1, `ADDR_FLAGS_A, 16'h0000, 6'h08);
        acc(1'h0, `ADDR_FLAGS_A, 16'h0000, 6'h00);
        chk("set wins", reg_rdata, 16'h0008);
        acc(1'h1, `ADDR_FLAGS_A, 16'h0000, 6'h00);
        chk("flags a clear", flags_a, 16'h0000);
        acc(1'h1, `ADDR_FLAGS_A, 16'hffff, 6'h00);
        chk("flags a write ones", flags_a, `FLAGS_A_MASK);
        // second reset in mid-run while flags are set
        @(posedge core_clk);
        reset_n <= 1'h0;
        @(posedge core_clk);
        reset_n <= 1'h1;
        #1;
        chk("flags a mid reset", flags_a, `FLAGS_RESET);
        acc(1'h0, `ADDR_FLAGS_A, 16'h0000, 6'h00);
        chk("flags a after reset", reg_rdata, `FLAGS_RESET);
        results;
    end
endmodule // interrupt_flag_status_bank_bench
